// file: hdl/isb_pkg.sv
// Package with opcodes, widths and carriers for the increment, skip, branch and OR unit.
package isb_pkg;

    // ****************************************
    // Widths and field positions
    // ****************************************
    localparam int DATA_W      = 8;
    localparam int FADDR_W     = 5;
    localparam int BRLIT_W     = 9;
    localparam int PC_W        = 11;
    localparam int PAGE_LO     = 5;
    localparam int PAGE_HI     = 6;
    localparam int ZERO_BIT    = 2;

    localparam logic [DATA_W-1:0]  ONE_8    = 8'h01;
    localparam logic [DATA_W-1:0]  ZERO_8   = 8'h00;
    localparam logic [PC_W-1:0]    PC_RST   = 11'h7FF;

    // ****************************************
    // Operation codes presented by decode
    // ****************************************
    typedef enum logic [2:0] {
        OP_NONE     = 3'h0,
        OP_INC      = 3'h1,
        OP_DEC_SKZ  = 3'h2,
        OP_INC_SKZ  = 3'h3,
        OP_BRANCH   = 3'h4,
        OP_OR_LIT   = 3'h5
    } isb_op_t;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic                  valid;
        isb_op_t               op;
        logic [FADDR_W-1:0]    fileAddr;
        logic                  destFile;
        logic [BRLIT_W-1:0]    literal;
    } isb_instr_t;

    typedef struct packed {
        logic                  we;
        logic [FADDR_W-1:0]    addr;
        logic [DATA_W-1:0]     data;
    } isb_fwrite_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_FLUSH = 2'b10
    } isb_state_t;

endpackage

// file: hdl/isb_unit.sv
// Execute unit for increment, skip-on-zero, branch and OR-literal operations.
`timescale 1ns/10ps
`default_nettype none

module isb_unit
    import isb_pkg::*;
(
    // Clock and reset.
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    // Instruction from decode and file read data for its address.
    input  wire isb_instr_t          instr,
    input  wire logic [DATA_W-1:0]   fileRdData,
    input  wire logic [DATA_W-1:0]   statusIn,
    // File register write port.
    output isb_fwrite_t              fileWr,
    // Accumulator, zero flag and program counter.
    output logic [DATA_W-1:0]        accum,
    output logic                     zeroFlag,
    output logic                     zeroWe,
    output logic [PC_W-1:0]          pc,
    output logic                     pcLoad,
    // Pipeline flush: the fetched instruction is replaced by a no-operation.
    output logic                     flush
);

    // ****************************************
    // State
    // ****************************************
    isb_state_t           state_q, state_d;
    logic [DATA_W-1:0]    accum_q, accum_d;
    logic                 zero_q, zero_d, zeroWe_q, zeroWe_d;
    logic [PC_W-1:0]      pc_q, pc_d;
    logic                 pcLoad_q, pcLoad_d;
    isb_fwrite_t          fw_q, fw_d;
    logic [DATA_W-1:0]    result;
    logic                 live;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        state_d  = ST_RUN;
        accum_d  = accum_q;
        zero_d   = zero_q;
        zeroWe_d = 1'b0;
        pc_d     = pc_q;
        pcLoad_d = 1'b0;
        fw_d     = '0;
        result   = ZERO_8;
        // The slot after a skip or branch executes as a no-operation.
        live     = instr.valid && (state_q == ST_RUN);
        if (live) begin
            case (instr.op)
                OP_INC:     result = fileRdData + ONE_8;
                OP_INC_SKZ: result = fileRdData + ONE_8;
                OP_DEC_SKZ: result = fileRdData - ONE_8;
                OP_OR_LIT:  result = accum_q | instr.literal[DATA_W-1:0];
                default:    result = ZERO_8;
            endcase
            case (instr.op)
                OP_INC, OP_INC_SKZ, OP_DEC_SKZ: begin
                    if (instr.destFile) begin
                        fw_d.we   = 1'b1;
                        fw_d.addr = instr.fileAddr;
                        fw_d.data = result;
                    end else begin
                        accum_d = result;
                    end
                    if (instr.op == OP_INC) begin
                        zero_d   = (result == ZERO_8);
                        zeroWe_d = 1'b1;
                    end else if (result == ZERO_8) begin
                        state_d = ST_FLUSH;
                    end
                end
                OP_BRANCH: begin
                    pc_d     = {statusIn[PAGE_HI:PAGE_LO], instr.literal};
                    pcLoad_d = 1'b1;
                    state_d  = ST_FLUSH;
                end
                OP_OR_LIT: begin
                    accum_d  = result;
                    zero_d   = (result == ZERO_8);
                    zeroWe_d = 1'b1;
                end
                default: begin
                    state_d = ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_q  <= ST_RUN;
            accum_q  <= ZERO_8;
            zero_q   <= 1'b0;
            zeroWe_q <= 1'b0;
            pc_q     <= PC_RST;
            pcLoad_q <= 1'b0;
            fw_q     <= '0;
        end else begin
            state_q  <= state_d;
            accum_q  <= accum_d;
            zero_q   <= zero_d;
            zeroWe_q <= zeroWe_d;
            pc_q     <= pc_d;
            pcLoad_q <= pcLoad_d;
            fw_q     <= fw_d;
        end
    end

    assign fileWr   = fw_q;
    assign accum    = accum_q;
    assign zeroFlag = zero_q;
    assign zeroWe   = zeroWe_q;
    assign pc       = pc_q;
    assign pcLoad   = pcLoad_q;
    assign flush    = (state_q == ST_FLUSH);

    // ****************************************
    // Checks
    // ****************************************
    sequence liveOp(isb_op_t o);
        instr.valid && state_q == ST_RUN && instr.op == o;
    endsequence

    sequence flushOnce;
        flush && !zeroWe ##1 !flush;
    endsequence

    dest_file_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_INC) and instr.destFile) |=> fileWr.we)
        else $error("File destination not written.");
    dest_accum_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_INC) and !instr.destFile) |=> !fileWr.we)
        else $error("Accumulator destination wrote file.");
    inc_value_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_INC) and instr.destFile) |=> fileWr.data == $past(fileRdData) + ONE_8)
        else $error("Increment value wrong.");
    dec_skip_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_DEC_SKZ) and fileRdData == ONE_8) |=> flush && !zeroWe)
        else $error("Decrement skip missing.");
    skip_nop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        flush |=> !fileWr.we && !pcLoad && !zeroWe)
        else $error("Skipped slot had effect.");
    inc_skip_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_INC_SKZ) and fileRdData == 8'hFF) |=> flush && !zeroWe)
        else $error("Increment skip missing.");
    branch_pc_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        liveOp(OP_BRANCH) |=> pcLoad && pc[BRLIT_W-1:0] == $past(instr.literal))
        else $error("Branch low bits wrong.");
    branch_page_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        liveOp(OP_BRANCH) |=> pc[PC_W-1:BRLIT_W] == $past(statusIn[PAGE_HI:PAGE_LO]))
        else $error("Branch page bits wrong.");
    branch_two_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        liveOp(OP_BRANCH) |=> flushOnce)
        else $error("Branch not two cycles.");
    or_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        liveOp(OP_OR_LIT) |=> zeroWe && accum == ($past(accum) | $past(instr.literal[DATA_W-1:0]))
            && zeroFlag == (accum == ZERO_8))
        else $error("OR result or zero flag wrong.");

    // ****************************************
    // Flag, value and slot checks
    // ****************************************
    inc_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        liveOp(OP_INC) |=> zeroWe && zeroFlag == ($past(fileRdData) == 8'hFF))
        else $error("Increment zero flag wrong.");
    dec_value_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_DEC_SKZ) and instr.destFile) |=> fileWr.we
            && fileWr.addr == $past(instr.fileAddr)
            && fileWr.data == $past(fileRdData) - ONE_8)
        else $error("Decrement value wrong.");
    dec_accum_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_DEC_SKZ) and !instr.destFile) |=> !fileWr.we
            && accum == $past(fileRdData) - ONE_8)
        else $error("Decrement to accumulator wrong.");
    dec_flags_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        liveOp(OP_DEC_SKZ) |=> !zeroWe && $stable(zeroFlag))
        else $error("Decrement touched zero flag.");
    no_dec_skip_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_DEC_SKZ) and fileRdData != ONE_8) |=> !flush)
        else $error("Decrement skipped on nonzero result.");
    inc_skip_value_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_INC_SKZ) and instr.destFile) |=> fileWr.we
            && fileWr.data == $past(fileRdData) + ONE_8)
        else $error("Increment skip value wrong.");
    accum_dest_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_INC_SKZ) and !instr.destFile) |=> !fileWr.we
            && accum == $past(fileRdData) + ONE_8)
        else $error("Increment to accumulator wrong.");
    inc_flags_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        liveOp(OP_INC_SKZ) |=> !zeroWe && $stable(zeroFlag))
        else $error("Increment skip touched zero flag.");
    no_inc_skip_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (liveOp(OP_INC_SKZ) and fileRdData != 8'hFF) |=> !flush)
        else $error("Increment skipped on nonzero result.");
    flush_one_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        flush |=> !flush)
        else $error("Flush lasted more than one cycle.");
    branch_flags_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        liveOp(OP_BRANCH) |=> !zeroWe && !fileWr.we && $stable(accum) && $stable(zeroFlag))
        else $error("Branch changed data or flags.");
    or_slot_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        liveOp(OP_OR_LIT) |=> !fileWr.we && !pcLoad && !flush)
        else $error("OR literal had side effects.");

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (PC_W != BRLIT_W + PAGE_HI - PAGE_LO + 1) begin : g_pcWidthBad
        $error("Branch target and page bits do not fill the program counter.");
    end
    if (PAGE_HI >= DATA_W || PAGE_LO > PAGE_HI) begin : g_pageBitsBad
        $error("Page select bits lie outside the status byte.");
    end

endmodule // isb_unit

`default_nettype wire

// file: testbench/isb_file_model.sv
// Model of the file register array behind the unit.
`timescale 1ns/10ps
`default_nettype none
module isb_file_model
    import isb_pkg::*;
(
    // Clock.
    input  wire logic               ref_clk,
    // Read and write ports.
    input  wire logic [FADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0]       rdData,
    input  wire isb_fwrite_t        fileWr
);
    logic [DATA_W-1:0] mem [32];
    initial for (int i = 0; i < 32; i++) mem[i] = 8'hF0 + 8'(i);
    assign rdData = mem[rdAddr];
    always @(posedge ref_clk) if (fileWr.we) mem[fileWr.addr] <= fileWr.data;
endmodule // isb_file_model
`default_nettype wire

// file: testbench/test_isb_unit.sv
// Self-checking bench for the increment, skip, branch and OR unit.
`timescale 1ns/10ps
`default_nettype none
module test_isb_unit
    import isb_pkg::*;
;
    typedef struct packed {
        isb_fwrite_t wr;
        logic [7:0]  acc;
        logic        zwe, z, pcl;
        logic [10:0] pc;
        logic        fl;
    } isb_note_t;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    isb_instr_t  instr = '0;
    logic [7:0]  statusIn = 8'h00, fileRdData, accum, r;
    isb_fwrite_t fileWr;
    logic        zeroFlag, zeroWe, pcLoad, flush, taken = 1'b0, fill = 1'b0;
    logic [10:0] pc;
    logic [4:0]  a;
    isb_op_t     op;
    int          mismatches = 0, checked = 0;
    isb_note_t   noteQ[$];
    isb_note_t   e, n;
    logic [7:0]  shadow [32];
    always #2.5 ref_clk = ~ref_clk;
    isb_unit i_isb_unit (.ref_clk(ref_clk), .reset_n(reset_n), .instr(instr),
        .fileRdData(fileRdData), .statusIn(statusIn), .fileWr(fileWr), .accum(accum),
        .zeroFlag(zeroFlag), .zeroWe(zeroWe), .pc(pc), .pcLoad(pcLoad), .flush(flush));
    isb_file_model i_isb_file_model (.ref_clk(ref_clk), .rdAddr(instr.fileAddr),
        .rdData(fileRdData), .fileWr(fileWr));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Holds reset for the given number of edges and checks the reset values.
    task automatic reset_dut(input int cycles);
        reset_n = 1'b0;
        repeat (cycles) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        e = '0;
        e.pc = PC_RST;
        check({accum, zeroFlag, zeroWe, pcLoad, flush, fileWr.we, pc}, {13'h0000, PC_RST});
    endtask
    // Drives one instruction, notes its expected result, and drives a filler increment into the slot when it is flushed.
    task automatic exec(input isb_op_t o, input logic [4:0] ad, input logic d,
                        input logic [8:0] k, input logic [7:0] s);
        @(posedge ref_clk) #1;
        instr = '{1'b1, o, ad, d, k};
        statusIn = s;
        fill = 1'b0;
        e.wr = '{d, ad, 8'h00};
        e.zwe = 1'b0;
        e.pcl = 1'b0;
        e.fl = 1'b0;
        r = (o == OP_DEC_SKZ) ? shadow[ad] - 8'h01 : shadow[ad] + 8'h01;
        case (o)
            OP_BRANCH: begin
                e.wr.we = 1'b0;
                e.pcl = 1'b1;
                e.pc = {s[6:5], k};
                e.fl = 1'b1;
            end
            OP_OR_LIT: begin
                e.wr.we = 1'b0;
                e.acc = e.acc | k[7:0];
                e.zwe = 1'b1;
                e.z = (e.acc == 8'h00);
            end
            default: begin
                e.wr.data = r;
                if (d) shadow[ad] = r;
                else e.acc = r;
                if (o == OP_INC) {e.zwe, e.z} = {1'b1, r == 8'h00};
                else e.fl = (r == 8'h00);
            end
        endcase
        noteQ.push_back(e);
        if (e.fl) begin
            @(posedge ref_clk) #1;
            instr = '{1'b1, OP_INC, 5'h1F, 1'b1, 9'h000};
            fill = 1'b1;
        end
    endtask
    always @(posedge ref_clk) taken <= reset_n && instr.valid && !fill && instr.op != OP_NONE;
    always @(negedge ref_clk) if (taken) begin
        n = noteQ.pop_front();
        check(fileWr.we, n.wr.we);
        if (n.wr.we) check({fileWr.addr, fileWr.data}, {n.wr.addr, n.wr.data});
        check(accum, n.acc);
        check({zeroWe, zeroFlag}, {n.zwe, n.z});
        check({pcLoad, pc}, {n.pcl, n.pc});
        check(flush, n.fl);
    end
    initial begin
        void'($urandom(94));
        for (int i = 0; i < 32; i++) shadow[i] = 8'hF0 + 8'(i);
        reset_dut(6);
        $display("test reset done");
        exec(OP_INC_SKZ, 5'h0F, 1'b1, 9'h000, 8'h00);
        exec(OP_INC, 5'h1F, 1'b0, 9'h000, 8'h00);
        exec(OP_INC, 5'h0F, 1'b1, 9'h000, 8'h00);
        exec(OP_DEC_SKZ, 5'h11, 1'b0, 9'h000, 8'h00);
        exec(OP_DEC_SKZ, 5'h12, 1'b1, 9'h000, 8'h00);
        exec(OP_OR_LIT, 5'h00, 1'b0, 9'h000, 8'h00);
        exec(OP_BRANCH, 5'h00, 1'b0, 9'h1FF, 8'h40);
        exec(OP_BRANCH, 5'h00, 1'b0, 9'h000, 8'h20);
        exec(OP_OR_LIT, 5'h00, 1'b0, 9'h0FF, 8'h00);
        @(posedge ref_clk) #1;
        instr = '{1'b1, OP_NONE, 5'h03, 1'b1, 9'h1FF};
        @(posedge ref_clk) #1;
        check({fileWr.we, zeroWe, pcLoad, flush, accum}, {4'h0, e.acc});
        reset_dut(2);
        $display("test directed done");
        a = 5'h00;
        repeat (80) begin
            op = isb_op_t'($urandom_range(5, 1));
            a = a + 5'($urandom_range(30, 1));
            exec(op, a, 1'($urandom), (op == OP_OR_LIT) ? 9'($urandom_range(255)) : 9'($urandom),
                 8'($urandom));
        end
        @(posedge ref_clk) #1;
        instr = '0;
        repeat (3) @(posedge ref_clk);
        check(noteQ.size(), 0);
        $display("test random done");
        report_and_stop;
    end
    initial begin
        #(5 * 2000);
        mismatches++;
        report_and_stop;
    end
endmodule // test_isb_unit
`default_nettype wire
